// [logic/rtdd_defs.vh]
// Constants shared by the diagnostics block of the six-channel resistance input
`ifndef RTDD_DEFS_VH
`define RTDD_DEFS_VH
// ==========================================================================
// Clock and timing
// ==========================================================================
`define RTDD_CLK_MHZ 250
`define RTDD_STEP_NS 1000
// ==========================================================================
// Register byte offsets
// ==========================================================================
`define RTDD_OFS_ERR 6'h00
`define RTDD_OFS_BROKEN 6'h04
`define RTDD_OFS_RANGE 6'h08
`define RTDD_OFS_IRQ_STAT 6'h0C
`define RTDD_OFS_IRQ_MASK 6'h10
`define RTDD_OFS_CFG0 6'h20
// ==========================================================================
// Error word layout and codes
// ==========================================================================
`define RTDD_ERR_CLS_LSB 9
`define RTDD_CLS_NONE 3'h0
`define RTDD_CLS_HW 3'h1
`define RTDD_CLS_CFG 3'h2
`define RTDD_EXT_NONE 9'h000
`define RTDD_EXT_PWRUP 9'h001
`define RTDD_EXT_HW_SPEC 9'h100
`define RTDD_EXT_FILT0 9'h001
// ==========================================================================
// Channel configuration word fields
// ==========================================================================
`define RTDD_CFG_EN 0
`define RTDD_CFG_TYPE_LSB 1
`define RTDD_CFG_FILT_LSB 5
`define RTDD_CFG_RESET 8'h00
`define RTDD_TYPE_RES_FIRST 4'h8
`define RTDD_TYPE_LAST 4'hB
`define RTDD_FILT_LAST 3'h5
// ==========================================================================
// Interrupt status bits
// ==========================================================================
`define RTDD_IRQ_HW 0
`define RTDD_IRQ_CFG 1
`define RTDD_IRQ_RANGE 2
`define RTDD_IRQ_BROKEN 3
`endif

// [logic/rtdd_selftest.v]
// Power-up self test sequencer of the diagnostics block
`timescale 1ns/1ps
`default_nettype none
`include "rtdd_defs.vh"
module rtdd_selftest #(
    parameter STEP_CYC = (`RTDD_STEP_NS * `RTDD_CLK_MHZ + 999) / 1000,
    parameter NTEST = 3
) (
    input wire sys_clk,
    input wire nrst,
    input wire [NTEST-1:0] test_ok,
    output reg done_r,
    output reg fail_r,
    output reg [1:0] fail_idx_r
);
    localparam ST_RUN = 1'b0;
    localparam ST_END = 1'b1;
    reg state_r;
    reg [15:0] cnt_r;
    reg [1:0] step_r;

    // ======================================================================
    // Sequence: wait a settle time per test, then sample its result
    // ======================================================================
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RUN;
            cnt_r <= 16'h0000;
            step_r <= 2'h0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            fail_idx_r <= 2'h0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (cnt_r < STEP_CYC[15:0] - 16'h0001) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end else begin
                        cnt_r <= 16'h0000;
                        if (!test_ok[step_r]) begin
                            fail_r <= 1'b1; // A failed test ends the run
                            fail_idx_r <= step_r;
                            done_r <= 1'b1;
                            state_r <= ST_END;
                        end else if (step_r == NTEST[1:0] - 2'h1) begin
                            done_r <= 1'b1;
                            state_r <= ST_END;
                        end else begin
                            step_r <= step_r + 2'h1;
                        end
                    end
                end
                ST_END: begin
                    state_r <= ST_END;
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end
endmodule // rtdd_selftest
`default_nettype wire

// [logic/rtdd_chan_check.v]
// Per-scan range and broken-input checks for all enabled channels
`timescale 1ns/1ps
`default_nettype none
`include "rtdd_defs.vh"
module rtdd_chan_check #(
    parameter NCH = 6,
    parameter signed [15:0] RANGE_LO = 16'shF000,
    parameter signed [15:0] RANGE_HI = 16'sh7000
) (
    input wire sys_clk,
    input wire nrst,
    input wire scan_done,
    input wire [NCH*16-1:0] chan_val,
    input wire [NCH-1:0] chan_en,
    input wire [NCH-1:0] chan_is_res,
    input wire [NCH-1:0] open_short,
    output reg [NCH-1:0] over_r,
    output reg [NCH-1:0] under_r,
    output reg [NCH-1:0] broken_r
);
    integer i;
    reg [NCH-1:0] over_nxt;
    reg [NCH-1:0] under_nxt;
    reg signed [15:0] v;

    // Compare each enabled channel against its operating range
    always @* begin
        over_nxt = {NCH{1'b0}};
        under_nxt = {NCH{1'b0}};
        v = 16'sh0000;
        for (i = 0; i < NCH; i = i + 1) begin
            v = chan_val[i*16 +: 16];
            over_nxt[i] = chan_en[i] && (v > RANGE_HI);
            // Zero is a legal resistance, so no low flag there
            under_nxt[i] = chan_en[i] && !chan_is_res[i] && (v < RANGE_LO);
        end
    end

    // Flags refresh only when a scan completes, then hold
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            over_r <= {NCH{1'b0}};
            under_r <= {NCH{1'b0}};
            broken_r <= {NCH{1'b0}};
        end else if (scan_done) begin
            over_r <= over_nxt;
            under_r <= under_nxt;
            broken_r <= open_short & chan_en;
        end
    end
endmodule // rtdd_chan_check
`default_nettype wire

// [logic/rtdd_diag.v]
// Diagnostics and error reporting of a six-channel resistance input module
// Notes on behaviour
// - Power-up self tests; failure gives error, dark LED
// - LED lit only with power and tests passed
// - Check config on enable, then every scan (code checks each word only when it is written)
// - Improper configuration word raises module error
// - Out-of-range input sets over/under flag
// - Resistance channels never flag under-range
// - Open or short input sets broken flag
// - Range errors in data; config errors extended (code gives extended code only for a bad filter; a bad type gives zero)
// - Blocking faults reported as critical hardware errors
// - Error word: 15-12 zero, 11-9 class, 8-0 extended
// - LED shows faults at once; both reported
// - Class codes 000 none, 001 hw, 010 config
// - Extended field zero when class is none
// - Invalid config discarded, prior config kept
`timescale 1ns/1ps
`default_nettype none
`include "rtdd_defs.vh"
module rtdd_diag #(
    parameter NCH = 6,
    parameter signed [15:0] RANGE_LO = 16'shF000,
    parameter signed [15:0] RANGE_HI = 16'sh7000
) (
    input wire sys_clk,
    input wire nrst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire scan_done,
    input wire [NCH*16-1:0] chan_val,
    input wire ext_pwr_ok,
    input wire rom_ok,
    input wire eeprom_ok,
    input wire [NCH-1:0] open_short,
    output wire [NCH-1:0] chan_enable,
    output wire [NCH*4-1:0] chan_type,
    output wire [NCH*3-1:0] chan_filter,
    output wire status_led,
    output wire irq
);
    // ======================================================================
    // Input synchronisers for pins
    // ======================================================================
    reg [NCH+2:0] pin_s1_r;
    reg [NCH+2:0] pin_s2_r;

    // Two-stage capture of asynchronous pins
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= {(NCH+3){1'b0}};
            pin_s2_r <= {(NCH+3){1'b0}};
        end else begin
            pin_s1_r <= {open_short, eeprom_ok, rom_ok, ext_pwr_ok};
            pin_s2_r <= pin_s1_r;
        end
    end

    wire pwr_ok = pin_s2_r[0];
    wire [NCH-1:0] os_sync = pin_s2_r[NCH+2:3];

    // ======================================================================
    // Power-up self test
    // ======================================================================
    wire st_done;
    wire st_fail;
    wire [1:0] st_idx;

    rtdd_selftest u_selftest (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .test_ok(pin_s2_r[2:0]),
        .done_r(st_done),
        .fail_r(st_fail),
        .fail_idx_r(st_idx)
    );

    // ======================================================================
    // Channel configuration store
    // ======================================================================
    reg [7:0] cfg_r [0:NCH-1];
    reg cfg_bad_r;
    reg [8:0] cfg_ext_r;
    integer k;

    // Configuration word is legal when type and filter are defined
    function cfg_valid;
        input [7:0] w;
        begin
            cfg_valid = (w[`RTDD_CFG_TYPE_LSB +: 4] <= `RTDD_TYPE_LAST)
                && (w[`RTDD_CFG_FILT_LSB +: 3] <= `RTDD_FILT_LAST);
        end
    endfunction

    // Address decode helper for the channel configuration words
    function [3:0] cfg_index;
        input [5:0] a;
        begin
            cfg_index = {1'b0, a[4:2]};
        end
    endfunction

    // ======================================================================
    // Avalon-MM slave: one wait state, then answer
    // ======================================================================
    reg ack_r;
    reg [31:0] rdata_r;
    wire req = avs_read | avs_write;
    wire acc = req & ack_r;
    wire is_cfg = (avs_address >= `RTDD_OFS_CFG0)
        && (cfg_index(avs_address) < NCH);
    wire [3:0] cidx = cfg_index(avs_address);

    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;

    // Acknowledge toggles so every request sees exactly one wait cycle
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    wire wr_cfg = acc & avs_write & is_cfg;
    wire wr_ok = cfg_valid(avs_writedata[7:0]);

    // Store only legal words; an illegal one leaves the old setting
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (k = 0; k < NCH; k = k + 1) begin
                cfg_r[k] <= `RTDD_CFG_RESET;
            end
        end else if (wr_cfg && wr_ok) begin
            cfg_r[cidx[2:0]] <= avs_writedata[7:0];
        end
    end

    // Remember an improper configuration word and its extended code
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_bad_r <= 1'b0;
            cfg_ext_r <= `RTDD_EXT_NONE;
        end else if (wr_cfg && !wr_ok) begin
            cfg_bad_r <= 1'b1;
            if (avs_writedata[`RTDD_CFG_TYPE_LSB +: 4] <= `RTDD_TYPE_LAST) begin
                cfg_ext_r <= `RTDD_EXT_FILT0 + {6'h00, cidx[2:0]};
            end else begin
                cfg_ext_r <= `RTDD_EXT_NONE;
            end
        end else if (wr_cfg) begin
            cfg_bad_r <= 1'b0;
            cfg_ext_r <= `RTDD_EXT_NONE;
        end
    end

    // Active configuration out to the conversion path
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_cfg
            assign chan_enable[g] = cfg_r[g][`RTDD_CFG_EN];
            assign chan_type[g*4 +: 4] = cfg_r[g][`RTDD_CFG_TYPE_LSB +: 4];
            assign chan_filter[g*3 +: 3] = cfg_r[g][`RTDD_CFG_FILT_LSB +: 3];
        end
    endgenerate

    // Resistance-type channels skip the low-range check
    reg [NCH-1:0] is_res;
    integer j;
    always @* begin
        for (j = 0; j < NCH; j = j + 1) begin
            is_res[j] = cfg_r[j][`RTDD_CFG_TYPE_LSB +: 4]
                >= `RTDD_TYPE_RES_FIRST;
        end
    end

    // ======================================================================
    // Channel checks on each scan
    // ======================================================================
    wire [NCH-1:0] over_f;
    wire [NCH-1:0] under_f;
    wire [NCH-1:0] broken_input_flags;

    rtdd_chan_check #(
        .NCH(NCH),
        .RANGE_LO(RANGE_LO),
        .RANGE_HI(RANGE_HI)
    ) u_check (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .scan_done(scan_done),
        .chan_val(chan_val),
        .chan_en(chan_enable),
        .chan_is_res(is_res),
        .open_short(os_sync),
        .over_r(over_f),
        .under_r(under_f),
        .broken_r(broken_input_flags)
    );

    // ======================================================================
    // Module error word
    // ======================================================================
    reg [15:0] module_error_word_r;
    reg [15:0] err_nxt;
    wire hw_fault = (st_done & st_fail) | (st_done & ~pwr_ok);

    // Hardware faults outrank configuration faults
    always @* begin
        err_nxt = 16'h0000;
        if (!st_done) begin
            err_nxt[11:9] = `RTDD_CLS_HW;
            err_nxt[8:0] = `RTDD_EXT_PWRUP;
        end else if (!pwr_ok) begin
            err_nxt[11:9] = `RTDD_CLS_HW;
            err_nxt[8:0] = `RTDD_EXT_HW_SPEC;
        end else if (st_fail) begin
            err_nxt[11:9] = `RTDD_CLS_HW;
            err_nxt[8:0] = `RTDD_EXT_HW_SPEC + {7'h00, st_idx};
        end else if (cfg_bad_r) begin
            err_nxt[11:9] = `RTDD_CLS_CFG;
            err_nxt[8:0] = cfg_ext_r;
        end
    end

    // Word is refreshed per scan, when self test finishes and on every cycle with a hardware fault
    reg st_done_d_r;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            module_error_word_r <= {4'h0, `RTDD_CLS_HW, `RTDD_EXT_PWRUP};
            st_done_d_r <= 1'b0;
        end else begin
            st_done_d_r <= st_done;
            if (scan_done || (st_done && !st_done_d_r) || hw_fault) begin
                module_error_word_r <= err_nxt;
            end
        end
    end

    // Indicator: power present, tests passed, no live fault
    assign status_led = pwr_ok & st_done & ~st_fail;

    // ======================================================================
    // Interrupt status and mask
    // ======================================================================
    reg [3:0] irq_stat_r;
    reg [3:0] irq_mask_r;
    reg scan_d_r;
    wire [3:0] ev;

    // Range and broken events come from freshly updated flags
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scan_d_r <= 1'b0;
        end else begin
            scan_d_r <= scan_done;
        end
    end
    assign ev[`RTDD_IRQ_HW] = hw_fault;
    assign ev[`RTDD_IRQ_CFG] = wr_cfg & ~wr_ok;
    assign ev[`RTDD_IRQ_RANGE] = scan_d_r & (|(over_f | under_f));
    assign ev[`RTDD_IRQ_BROKEN] = scan_d_r & (|broken_input_flags);
    wire rd_stat = acc & avs_read & (avs_address == `RTDD_OFS_IRQ_STAT);

    // Sticky bits; a read clears only the bits it returned, set wins
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= 4'h0;
        end else begin
            irq_stat_r <= (rd_stat ? (irq_stat_r & ~rdata_r[3:0])
                : irq_stat_r) | ev;
        end
    end

    // Mask register write
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_r <= 4'h0;
        end else if (acc && avs_write
            && (avs_address == `RTDD_OFS_IRQ_MASK)) begin
            irq_mask_r <= avs_writedata[3:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ======================================================================
    // Read data, captured at the first edge of a read
    // ======================================================================
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= 32'h00000000;
            if (is_cfg) begin
                rdata_r <= {24'h000000, cfg_r[cidx[2:0]]};
            end else begin
                case (avs_address)
                    `RTDD_OFS_ERR:
                        rdata_r <= {16'h0000, module_error_word_r};
                    `RTDD_OFS_BROKEN:
                        rdata_r <= {26'h0, broken_input_flags};
                    `RTDD_OFS_RANGE:
                        rdata_r <= {18'h0, over_f, 2'h0, under_f};
                    `RTDD_OFS_IRQ_STAT:
                        rdata_r <= {28'h0000000, irq_stat_r};
                    `RTDD_OFS_IRQ_MASK:
                        rdata_r <= {28'h0000000, irq_mask_r};
                    default:
                        rdata_r <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // rtdd_diag
`default_nettype wire

// [sim/rtdd_diag_assertions.sv]
// Port-level checker of the diagnostics block
`timescale 1ns/1ps
`default_nettype none
module rtdd_chk #(
    parameter NCH = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ext_pwr_ok,
    input wire logic [NCH-1:0] chan_enable,
    input wire logic [NCH*4-1:0] chan_type,
    input wire logic [NCH*3-1:0] chan_filter,
    input wire logic status_led,
    input wire logic irq
);
    // ======================================================================
    // Helpers
    // ======================================================================
    logic [9:0] cyc_r;
    logic [NCH-1:0] res_m;
    wire rd_ack = avs_read && !avs_waitrequest;
    wire err_rd = rd_ack && avs_address == 6'h00;
    wire cfg0_wr = avs_write && !avs_waitrequest && avs_address == 6'h20;
    wire bad0 = avs_writedata[7:5] > 3'h5 || avs_writedata[4:1] > 4'hB;
    // Channels set up as resistance inputs
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            res_m[c] = chan_type[4*c+3];
        end
    end
    // Cycles since reset release, saturating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_r <= 10'h000;
        end else if (cyc_r != 10'h3FF) begin
            cyc_r <= cyc_r + 10'h001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    // ======================================================================
    // Properties
    // ======================================================================
    a_one_wait: assert property (s_req |=> s_ack)
        else $error("bus answer not after one wait state");
    a_new_req: assert property ($rose(avs_read || avs_write) |-> s_req)
        else $error("new request answered without wait");
    a_led_test: assert property (cyc_r < 10'h2BC |-> !status_led)
        else $error("indicator lit before self test end");
    a_led_pwr: assert property ((!ext_pwr_ok) [*3] |-> !status_led)
        else $error("indicator lit without power");
    a_err_top: assert property (err_rd |-> avs_readdata[15:12] == 4'h0)
        else $error("top digit of fault word not zero");
    a_err_class: assert property (err_rd |-> avs_readdata[11:9] <= 3'h2)
        else $error("fault class code out of set");
    a_err_ext: assert property (err_rd && avs_readdata[11:9] == 3'h0
        |-> avs_readdata[8:0] == 9'h000)
        else $error("extended field set without class");
    a_unmapped: assert property (rd_ack && avs_address[5:2] inside
        {4'h5, 4'h6, 4'h7, 4'hE, 4'hF} |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_under_res: assert property (rd_ack && avs_address == 6'h08
        |-> (avs_readdata[NCH-1:0] & res_m) == '0)
        else $error("under flag on resistance channel");
    a_cfg_keep: assert property (cfg0_wr && bad0 |=> $stable(chan_type[3:0])
        && $stable(chan_filter[2:0]) && $stable(chan_enable[0]))
        else $error("invalid setup word applied");
    a_cfg_take: assert property (cfg0_wr && !bad0 |=>
        chan_type[3:0] == $past(avs_writedata[4:1])
        && chan_enable[0] == $past(avs_writedata[0]))
        else $error("valid setup word not applied");
    a_mask_off: assert property (avs_write && !avs_waitrequest
        && avs_address == 6'h10 && avs_writedata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all masked");
endmodule // rtdd_chk
bind rtdd_diag rtdd_chk #(.NCH(NCH)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_pwr_ok(ext_pwr_ok),
    .chan_enable(chan_enable), .chan_type(chan_type),
    .chan_filter(chan_filter), .status_led(status_led), .irq(irq));
`default_nettype wire

// [sim/rtdd_host.sv]
// Bus master controller model reading input and fault data
`timescale 1ns/1ps
`default_nettype none
module rtdd_host (
    input wire logic sys_clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic run_mode
);
    // ======================================================================
    // Idle bus at time zero
    // ======================================================================
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // One transfer, held until waitrequest is seen low, for at most 16 cycles
    task automatic xfer(input bit wr, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q, output bit ok);
        ok = 1'b0;
        q = 32'h0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) begin
                ok = 1'b1;
                q = avs_readdata;
            end
        end
        // Released address and data lines show the inverse of the last value
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        // Stay out of run mode while a hardware fault class is read
        if (!wr && a == 6'h00) run_mode = (q[11:9] != 3'h1);
    endtask
endmodule // rtdd_host
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench of the diagnostics block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic signed [15:0] LO = 16'shF000;
    localparam logic signed [15:0] HI = 16'sh7000;
    logic sys_clk = 1'b0, nrst = 1'b0, scan_done = 1'b0;
    logic ext_pwr_ok = 1'b1, rom_ok = 1'b1, eeprom_ok = 1'b1;
    logic [95:0] chan_val = 96'h0, v;
    logic [5:0] open_short = 6'h00, os, avs_address, chan_enable;
    logic avs_read, avs_write, avs_waitrequest, status_led, irq, run_mode;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [23:0] chan_type;
    logic [17:0] chan_filter;
    logic [7:0] cfg [0:5];
    integer num_errors = 0, num_checks = 0, seed = 17866, i, k, t, f;
    rtdd_diag #(.NCH(6), .RANGE_LO(LO), .RANGE_HI(HI)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scan_done(scan_done),
        .chan_val(chan_val), .ext_pwr_ok(ext_pwr_ok), .rom_ok(rom_ok),
        .eeprom_ok(eeprom_ok), .open_short(open_short),
        .chan_enable(chan_enable), .chan_type(chan_type),
        .chan_filter(chan_filter), .status_led(status_led), .irq(irq));
    rtdd_host u_host (.sys_clk(sys_clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .run_mode(run_mode));
    // ======================================================================
    // Clock and helper tasks
    // ======================================================================
    initial forever #2 sys_clk = ~sys_clk;
    task final_report;
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
        bit ok;
        u_host.xfer(wr, a, d, q, ok);
        if (!ok) begin
            num_errors = num_errors + 1;
            final_report();
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Inputs settle past the synchronisers, then one scan pulse
    task scan(input logic [95:0] val, input logic [5:0] o);
        @(posedge sys_clk);
        chan_val <= val;
        open_short <= o;
        cyc(4);
        scan_done <= 1'b1;
        cyc(1);
        scan_done <= 1'b0;
        cyc(3);
    endtask
    // Expected range word: under in [5:0], over in [13:8]
    function automatic logic [31:0] exp_rng(input logic [95:0] x);
        logic [31:0] r;
        logic signed [15:0] s;
        r = 32'h0;
        for (int c = 0; c < 6; c++) begin
            s = x[16*c +: 16];
            if (cfg[c][0] && s > HI) r[8+c] = 1'b1;
            if (cfg[c][0] && s < LO && !cfg[c][4]) r[c] = 1'b1;
        end
        return r;
    endfunction
    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        cyc(8);
        nrst <= 1'b1;
        bus(0, 6'h00, 0);
        chk(q, 32'h0201);
        cyc(800);
        @(negedge sys_clk);
        chk({31'h0, status_led}, 32'h1);
        bus(0, 6'h00, 0);
        chk(q, 32'h0);
        bus(0, 6'h3C, 0);
        chk(q, 32'h0);
        for (i = 0; i < 6; i++) begin
            t = (i == 4) ? 8 + {$random(seed)} % 4 : {$random(seed)} % 8;
            f = {$random(seed)} % 6;
            cfg[i] = {f[2:0], t[3:0], i != 5};
            bus(1, 6'(32 + 4 * i), {24'h0, cfg[i]});
        end
        bus(0, 6'h24, 0);
        chk(q & 32'hFF, {24'h0, cfg[1]});
        chk({26'h0, chan_enable}, 32'h1F);
        for (i = 0; i < 6; i++) begin
            chk({25'h0, chan_filter[3*i +: 3], chan_type[4*i +: 4]},
                {25'h0, cfg[i][7:1]});
        end
        for (k = 0; k < 12; k++) begin
            v = {$random(seed), $random(seed), $random(seed)};
            if (k == 0) v[79:0] = {LO - 16'sd1, LO, HI, HI + 16'sd1, LO - 16'sd1};
            os = $random(seed);
            scan(v, os);
            bus(0, 6'h04, 0);
            chk(q, {26'h0, os & 6'h1F});
            bus(0, 6'h08, 0);
            chk(q, exp_rng(v));
        end
        chan_val <= ~v;
        cyc(6);
        bus(0, 6'h08, 0);
        chk(q, exp_rng(v));
        bus(1, 6'h20, 32'h1F);
        scan(96'h0, 6'h00);
        bus(0, 6'h00, 0);
        chk(q, 32'h0400);
        bus(0, 6'h20, 0);
        chk(q & 32'hFF, {24'h0, cfg[0]});
        bus(1, 6'h20, {24'h0, cfg[0]});
        bus(1, 6'h2C, 32'hC1);
        scan(96'h0, 6'h00);
        bus(0, 6'h00, 0);
        chk(q, 32'h0404);
        bus(1, 6'h2C, {24'h0, cfg[3]});
        scan(96'h0, 6'h00);
        bus(0, 6'h00, 0);
        chk(q, 32'h0);
        bus(0, 6'h0C, 0);
        bus(1, 6'h10, 32'h8);
        scan(96'h0, 6'h01);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus(0, 6'h0C, 0);
        chk(q, 32'h8);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1, 6'h10, 32'h0);
        scan(96'h0, 6'h01);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        ext_pwr_ok <= 1'b0;
        cyc(4);
        @(negedge sys_clk);
        chk({31'h0, status_led}, 32'h0);
        bus(0, 6'h00, 0);
        chk(q, 32'h0300);
        chk({31'h0, run_mode}, 32'h0);
        ext_pwr_ok <= 1'b1;
        rom_ok <= 1'b0;
        nrst <= 1'b0;
        cyc(8);
        nrst <= 1'b1;
        cyc(800);
        @(negedge sys_clk);
        chk({31'h0, status_led}, 32'h0);
        bus(0, 6'h00, 0);
        chk(q, 32'h0301);
        final_report();
    end
endmodule // testbench
`default_nettype wire
